/* File: core/ppi_pkg.sv */
// Constants shared by the pin interrupt and pin multiplexing block.
// Assumes a 32-bit APB register bus with byte addresses in paddr[11:0].
package ppi_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Sizes
	localparam int PPI_NPIN    = 32;
	localparam int PPI_NCH     = 4;
	localparam int PPI_NHALF   = 4;
	localparam int PPI_HALF_W  = 8;
	localparam int PPI_NPERIPH = 4;
	localparam int PPI_SEL_W   = 3;
	localparam int PPI_ASG_W   = 2;
	localparam int PPI_NLANE   = 4;
	localparam int PPI_NMUXREG = 4;
	localparam int PPI_MUX_FLD = 4;
	localparam int PPI_ADDR_W  = 12;

	////////////////////////////////////////////////////////////////////////////
	// Address map: channel c at c * 0x40, mux registers from 0x100
	localparam int PPI_CH_SH = 6;
	localparam logic [3:0] PPI_CH_REGION = 4'h0;
	localparam logic [5:0] PPI_OFS_MSK_SET  = 6'h00;
	localparam logic [5:0] PPI_OFS_MSK_CLR  = 6'h04;
	localparam logic [5:0] PPI_OFS_REQ      = 6'h08;
	localparam logic [5:0] PPI_OFS_LAT      = 6'h0C;
	localparam logic [5:0] PPI_OFS_LAT_SET  = 6'h10;
	localparam logic [5:0] PPI_OFS_EDGE_SET = 6'h14;
	localparam logic [5:0] PPI_OFS_EDGE_CLR = 6'h18;
	localparam logic [5:0] PPI_OFS_INV_SET  = 6'h1C;
	localparam logic [5:0] PPI_OFS_INV_CLR  = 6'h20;
	localparam logic [5:0] PPI_OFS_ASSIGN   = 6'h24;
	localparam logic [5:0] PPI_OFS_PINSTATE = 6'h28;
	localparam logic [11:0] PPI_MUX_BASE    = 12'h100;
	localparam logic [11:0] PPI_MUX_LAST    = 12'h10C;
	localparam logic [11:0] PPI_OFS_IEN     = 12'h110;

	////////////////////////////////////////////////////////////////////////////
	// Reset values and field masks
	localparam logic [31:0] PPI_RST_WORD   = 32'h0000_0000;
	localparam logic [7:0]  PPI_RST_ASSIGN = 8'hE4;
	localparam logic [31:0] PPI_MUX_MASK   = 32'h7777_7777;
	localparam logic [31:0] PPI_ASG_MASK   = 32'h0000_00FF;

	////////////////////////////////////////////////////////////////////////////
	// Function select codes
	localparam logic [2:0] PPI_SEL_GPIO = 3'h0;
	localparam logic [2:0] PPI_SEL_MAX  = 3'h4;

endpackage

/* File: core/ppi_chan.sv */
// One pin interrupt channel: polarity, edge/level detect, latches, mask.
// Assumes pin levels already synchronised to clk.
`timescale 1ns/1ps
module ppi_chan
(
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst,
	// Configuration
	input  wire logic [ppi_pkg::PPI_NPIN-1:0]  pin_level,
	input  wire logic [ppi_pkg::PPI_NPIN-1:0]  edge_mode,
	input  wire logic [ppi_pkg::PPI_NPIN-1:0]  invert,
	input  wire logic [ppi_pkg::PPI_NPIN-1:0]  mask,
	// Software latch access
	input  wire logic [ppi_pkg::PPI_NPIN-1:0]  latch_clr,
	input  wire logic [ppi_pkg::PPI_NPIN-1:0]  latch_set,
	// State
	output logic      [ppi_pkg::PPI_NPIN-1:0]  latch,
	output logic      [ppi_pkg::PPI_NPIN-1:0]  active,
	output logic                               irq
);
	import ppi_pkg::*;

	logic [PPI_NPIN-1:0] prev_reg;
	logic [PPI_NPIN-1:0] latch_reg;
	logic [PPI_NPIN-1:0] latch_next;
	logic [PPI_NPIN-1:0] rise;
	logic [PPI_NPIN-1:0] set_src;
	logic                irq_reg;

	////////////////////////////////////////////////////////////////////////////
	// Detection
	assign active     = pin_level ^ invert;
	assign rise       = active & ~prev_reg;
	assign set_src    = (edge_mode & rise) | (~edge_mode & active);
	// New events win over a clear in the same cycle
	assign latch_next = (latch_reg & ~latch_clr) | set_src | latch_set;
	assign latch      = latch_reg;
	assign irq        = irq_reg;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			prev_reg  <= PPI_RST_WORD;
			latch_reg <= PPI_RST_WORD;
			irq_reg   <= 1'b0;
		end
		else
		begin
			prev_reg  <= active;
			latch_reg <= latch_next;
			irq_reg   <= |(latch_next & mask);
		end
	end

endmodule

/* File: core/ppi_mux.sv */
// Per-pin function multiplexer with pad loopback.
// Assumes pad_in is already synchronised; peripheral buses are packed
// with peripheral k in bits [k*32 +: 32].
`timescale 1ns/1ps
module ppi_mux
(
	// Clock and reset
	input  wire logic                                           clk,
	input  wire logic                                           rst,
	// Selection
	input  wire logic [ppi_pkg::PPI_NPIN*ppi_pkg::PPI_SEL_W-1:0]  sel,
	input  wire logic [ppi_pkg::PPI_NPIN-1:0]                   in_en,
	// Sources
	input  wire logic [ppi_pkg::PPI_NPIN-1:0]                   gpio_out,
	input  wire logic [ppi_pkg::PPI_NPIN-1:0]                   gpio_oe,
	input  wire logic [ppi_pkg::PPI_NPERIPH*ppi_pkg::PPI_NPIN-1:0] periph_out,
	input  wire logic [ppi_pkg::PPI_NPERIPH*ppi_pkg::PPI_NPIN-1:0] periph_oe,
	// Pad side
	input  wire logic [ppi_pkg::PPI_NPIN-1:0]                   pad_in_sync,
	output logic      [ppi_pkg::PPI_NPIN-1:0]                   pad_out,
	output logic      [ppi_pkg::PPI_NPIN-1:0]                   pad_oe,
	// Receive side
	output logic      [ppi_pkg::PPI_NPIN-1:0]                   rx_data,
	output logic      [ppi_pkg::PPI_NPIN-1:0]                   pin_state
);
	import ppi_pkg::*;

	logic [PPI_NPIN-1:0] out_next;
	logic [PPI_NPIN-1:0] oe_next;
	logic [PPI_NPIN-1:0] out_reg;
	logic [PPI_NPIN-1:0] oe_reg;
	logic [PPI_NPIN-1:0] rx_reg;
	logic [PPI_NPIN-1:0] raw;

	genvar p;
	generate
		for (p = 0; p < PPI_NPIN; p++)
		begin : g_pin
			wire [PPI_SEL_W-1:0] s = sel[p*PPI_SEL_W +: PPI_SEL_W];
			wire [1:0]           k = s[1:0] - 2'h1;
			wire                 is_per = (s != PPI_SEL_GPIO) && (s <= PPI_SEL_MAX);
			// Codes above the last peripheral fall back to GPIO
			assign out_next[p] = is_per ? periph_out[k*PPI_NPIN + p] : gpio_out[p];
			assign oe_next[p]  = is_per ? periph_oe[k*PPI_NPIN + p] : gpio_oe[p];
			// Driven level is fed back before the pad when both enables are on
			assign raw[p] = (oe_reg[p] & in_en[p]) ? out_reg[p] : pad_in_sync[p];
		end
	endgenerate

	assign pad_out   = out_reg;
	assign pad_oe    = oe_reg;
	assign rx_data   = rx_reg;
	assign pin_state = raw;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			out_reg <= PPI_RST_WORD;
			oe_reg  <= PPI_RST_WORD;
			rx_reg  <= PPI_RST_WORD;
		end
		else
		begin
			out_reg <= out_next;
			oe_reg  <= oe_next;
			rx_reg  <= raw & in_en;
		end
	end

endmodule

/* File: core/ppi_top.sv */
// Pin interrupt controller with pin multiplexer, APB register slave.
// Assumes a single 200 MHz clock; pad inputs are asynchronous.
`timescale 1ns/1ps
module ppi_top
(
	// Clock and reset
	input  wire logic                                              clk,
	input  wire logic                                              rst,
	// APB slave
	input  wire logic                                              psel,
	input  wire logic                                              penable,
	input  wire logic                                              pwrite,
	input  wire logic [ppi_pkg::PPI_ADDR_W-1:0]                    paddr,
	input  wire logic [31:0]                                       pwdata,
	output logic      [31:0]                                       prdata,
	output logic                                                   pready,
	output logic                                                   pslverr,
	// GPIO and peripheral sources
	input  wire logic [ppi_pkg::PPI_NPIN-1:0]                      gpio_out,
	input  wire logic [ppi_pkg::PPI_NPIN-1:0]                      gpio_oe,
	input  wire logic [ppi_pkg::PPI_NPERIPH*ppi_pkg::PPI_NPIN-1:0] periph_out,
	input  wire logic [ppi_pkg::PPI_NPERIPH*ppi_pkg::PPI_NPIN-1:0] periph_oe,
	// Pads
	input  wire logic [ppi_pkg::PPI_NPIN-1:0]                      pad_in,
	output logic      [ppi_pkg::PPI_NPIN-1:0]                      pad_out,
	output logic      [ppi_pkg::PPI_NPIN-1:0]                      pad_oe,
	// Receive data to GPIO and peripherals
	output logic      [ppi_pkg::PPI_NPIN-1:0]                      rx_data,
	// Interrupts
	output logic      [ppi_pkg::PPI_NCH-1:0]                       pin_irq_channel,
	output logic                                                   irq
);
	import ppi_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Address decoding helpers
	function automatic logic is_ch(input logic [PPI_ADDR_W-1:0] a);
		return a[PPI_ADDR_W-1:PPI_CH_SH+2] == PPI_CH_REGION;
	endfunction

	function automatic logic [1:0] ch_of(input logic [PPI_ADDR_W-1:0] a);
		return a[PPI_CH_SH+1:PPI_CH_SH];
	endfunction

	function automatic logic is_mux(input logic [PPI_ADDR_W-1:0] a);
		return (a >= PPI_MUX_BASE) && (a <= PPI_MUX_LAST) && (a[1:0] == 2'h0);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Pad input synchroniser
	logic [PPI_NPIN-1:0] sync1_reg;
	logic [PPI_NPIN-1:0] sync2_reg;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sync1_reg <= PPI_RST_WORD;
			sync2_reg <= PPI_RST_WORD;
		end
		else
		begin
			sync1_reg <= pad_in;
			sync2_reg <= sync1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus decode
	wire        acc_wr  = psel & penable & pwrite;
	wire        setup   = psel & ~penable;
	wire [5:0]  ofs     = paddr[PPI_CH_SH-1:0];
	wire        ch_hit  = is_ch(paddr) && (ofs <= PPI_OFS_PINSTATE) && (ofs[1:0] == 2'h0);
	wire        mux_hit = is_mux(paddr);
	wire        ien_hit = paddr == PPI_OFS_IEN;
	wire [1:0]  mux_idx = paddr[3:2];

	////////////////////////////////////////////////////////////////////////////
	// Mux select and input enable registers
	logic [31:0]                   mux_reg [PPI_NMUXREG];
	logic [31:0]                   ien_reg;
	logic [PPI_NPIN*PPI_SEL_W-1:0] sel_flat;
	logic [PPI_NPIN-1:0]           pin_state;

	genvar m;
	generate
		for (m = 0; m < PPI_NMUXREG; m++)
		begin : g_muxreg
			wire wr = acc_wr & mux_hit & (mux_idx == 2'(m));
			always_ff @(posedge clk)
			begin
				if (rst)
					mux_reg[m] <= PPI_RST_WORD;
				else if (wr)
					mux_reg[m] <= pwdata & PPI_MUX_MASK;
			end
		end
		for (m = 0; m < PPI_NPIN; m++)
		begin : g_sel
			assign sel_flat[m*PPI_SEL_W +: PPI_SEL_W] =
				mux_reg[m / 8][(m % 8) * PPI_MUX_FLD +: PPI_SEL_W];
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (rst)
			ien_reg <= PPI_RST_WORD;
		else if (acc_wr & ien_hit)
			ien_reg <= pwdata;
	end

	ppi_mux u_mux
	(
		.clk         (clk),
		.rst         (rst),
		.sel         (sel_flat),
		.in_en       (ien_reg),
		.gpio_out    (gpio_out),
		.gpio_oe     (gpio_oe),
		.periph_out  (periph_out),
		.periph_oe   (periph_oe),
		.pad_in_sync (sync2_reg),
		.pad_out     (pad_out),
		.pad_oe      (pad_oe),
		.rx_data     (rx_data),
		.pin_state   (pin_state)
	);

	////////////////////////////////////////////////////////////////////////////
	// Interrupt channels
	logic [31:0]          rd_ch   [PPI_NCH];
	logic [PPI_NCH-1:0]   ch_irq;

	genvar c;
	generate
		for (c = 0; c < PPI_NCH; c++)
		begin : g_ch
			logic [31:0] mask_reg;
			logic [31:0] edge_reg;
			logic [31:0] inv_reg;
			logic [7:0]  asg_reg;
			logic [31:0] mask_next;
			logic [31:0] edge_next;
			logic [31:0] inv_next;
			logic [31:0] src;
			logic [31:0] latch;
			logic [31:0] active;
			logic [31:0] lat_clr;
			logic [31:0] lat_set;
			logic [31:0] rd;
			wire         wr = acc_wr & ch_hit & (ch_of(paddr) == 2'(c));

			// Set and clear aliases keep untouched bits as they were
			assign mask_next = (wr && ofs == PPI_OFS_MSK_SET)  ? mask_reg | pwdata :
			                   (wr && ofs == PPI_OFS_MSK_CLR)  ? mask_reg & ~pwdata :
			                   mask_reg;
			assign edge_next = (wr && ofs == PPI_OFS_EDGE_SET) ? edge_reg | pwdata :
			                   (wr && ofs == PPI_OFS_EDGE_CLR) ? edge_reg & ~pwdata :
			                   edge_reg;
			assign inv_next  = (wr && ofs == PPI_OFS_INV_SET)  ? inv_reg | pwdata :
			                   (wr && ofs == PPI_OFS_INV_CLR)  ? inv_reg & ~pwdata :
			                   inv_reg;
			assign lat_clr = (wr && (ofs == PPI_OFS_REQ || ofs == PPI_OFS_LAT)) ?
			                 pwdata : PPI_RST_WORD;
			assign lat_set = (wr && ofs == PPI_OFS_LAT_SET) ? pwdata : PPI_RST_WORD;

			always_ff @(posedge clk)
			begin
				if (rst)
				begin
					mask_reg <= PPI_RST_WORD;
					edge_reg <= PPI_RST_WORD;
					inv_reg  <= PPI_RST_WORD;
					asg_reg  <= PPI_RST_ASSIGN;
				end
				else
				begin
					mask_reg <= mask_next;
					edge_reg <= edge_next;
					inv_reg  <= inv_next;
					if (wr && ofs == PPI_OFS_ASSIGN)
						asg_reg <= pwdata[7:0];
				end
			end

			// Each byte lane of the channel takes one whole half port
			for (m = 0; m < PPI_NLANE; m++)
			begin : g_lane
				wire [PPI_ASG_W-1:0] h = asg_reg[m*PPI_ASG_W +: PPI_ASG_W];
				assign src[m*PPI_HALF_W +: PPI_HALF_W] =
					pin_state[h*PPI_HALF_W +: PPI_HALF_W];
			end

			ppi_chan u_chan
			(
				.clk       (clk),
				.rst       (rst),
				.pin_level (src),
				.edge_mode (edge_reg),
				.invert    (inv_reg),
				.mask      (mask_reg),
				.latch_clr (lat_clr),
				.latch_set (lat_set),
				.latch     (latch),
				.active    (active),
				.irq       (ch_irq[c])
			);

			// Latches and pin states read regardless of the mask
			always_comb
			begin
				rd = PPI_RST_WORD;
				case (ofs)
					PPI_OFS_MSK_SET,
					PPI_OFS_MSK_CLR:  rd = mask_reg;
					PPI_OFS_REQ:      rd = latch & mask_reg;
					PPI_OFS_LAT,
					PPI_OFS_LAT_SET:  rd = latch;
					PPI_OFS_EDGE_SET,
					PPI_OFS_EDGE_CLR: rd = edge_reg;
					PPI_OFS_INV_SET,
					PPI_OFS_INV_CLR:  rd = inv_reg;
					PPI_OFS_ASSIGN:   rd = {24'h00_0000, asg_reg};
					PPI_OFS_PINSTATE: rd = src;
					default:          rd = PPI_RST_WORD;
				endcase
			end
			assign rd_ch[c] = rd;
		end
	endgenerate

	assign pin_irq_channel = ch_irq;
	assign irq             = |ch_irq;

	////////////////////////////////////////////////////////////////////////////
	// Read data and response
	logic [31:0] prdata_reg;
	logic        err_reg;
	wire  [31:0] rd_val = ch_hit  ? rd_ch[ch_of(paddr)] :
	                      mux_hit ? mux_reg[mux_idx] :
	                      ien_hit ? ien_reg : PPI_RST_WORD;
	wire         hit    = ch_hit | mux_hit | ien_hit;

	// Read data is captured in setup so the access phase answers at once
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			prdata_reg <= PPI_RST_WORD;
			err_reg    <= 1'b0;
		end
		else if (setup)
		begin
			prdata_reg <= rd_val;
			err_reg    <= ~hit;
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & err_reg;

endmodule

/* File: verification/ppi_pins.sv */
// Behavioural drivers on the port pins outside the block.
// Assumes pad_oe high means the block drives that pin.
`timescale 1ns/1ps
module ppi_pins
(
	// Block side
	input  wire logic [ppi_pkg::PPI_NPIN-1:0] pad_out,
	input  wire logic [ppi_pkg::PPI_NPIN-1:0] pad_oe,
	// Bench control
	input  wire logic [ppi_pkg::PPI_NPIN-1:0] ext_lvl,
	input  wire logic [ppi_pkg::PPI_NPIN-1:0] fight,
	// Pad level seen by the block
	output logic      [ppi_pkg::PPI_NPIN-1:0] pad_in
);
	import ppi_pkg::*;
	////////////////////////////////////////////////////////////////////////////
	// An overdriving source wins, so a loopback can be told apart from the pad
	assign pad_in = (pad_oe & ~fight & pad_out) | ((~pad_oe | fight) & ext_lvl);
endmodule

/* File: verification/ppi_top_monitor.sv */
// Concurrent checks on the ports of ppi_top, bound into every instance.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module ppi_top_monitor
(
	// Clock and reset
	input wire logic                                              clk,
	input wire logic                                              rst,
	// APB
	input wire logic                                              psel,
	input wire logic                                              penable,
	input wire logic                                              pwrite,
	input wire logic [31:0]                                       prdata,
	input wire logic                                              pready,
	input wire logic                                              pslverr,
	// Sources and pads
	input wire logic [ppi_pkg::PPI_NPIN-1:0]                      gpio_out,
	input wire logic [ppi_pkg::PPI_NPIN-1:0]                      gpio_oe,
	input wire logic [ppi_pkg::PPI_NPERIPH*ppi_pkg::PPI_NPIN-1:0] periph_out,
	input wire logic [ppi_pkg::PPI_NPERIPH*ppi_pkg::PPI_NPIN-1:0] periph_oe,
	input wire logic [ppi_pkg::PPI_NPIN-1:0]                      pad_out,
	input wire logic [ppi_pkg::PPI_NPIN-1:0]                      pad_oe,
	input wire logic [ppi_pkg::PPI_NPIN-1:0]                      rx_data,
	// Interrupts
	input wire logic [ppi_pkg::PPI_NCH-1:0]                       pin_irq_channel,
	input wire logic                                              irq
);
	import ppi_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	wire wr_acc;
	assign wr_acc = psel && penable && pwrite;
	////////////////////////////////////////////////////////////////////////////
	chk_ready_high: assert property (pready)
		else $error("pready low");
	chk_irq_or: assert property (irq == |pin_irq_channel)
		else $error("irq differs from channel outputs");
	chk_err_phase: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access phase");
	chk_err_rdzero: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
		else $error("refused read returned data");
	chk_reset_quiet: assert property ($fell(rst) |-> pad_oe == 32'h0
		&& rx_data == 32'h0 && pin_irq_channel == 4'h0)
		else $error("outputs not cleared by reset");
	// Requests drop only through a register write; a mask clear lands one cycle late
	chk_latch_hold: assert property (pin_irq_channel != 4'h0
		&& !wr_acc && !$past(wr_acc) |=>
		(pin_irq_channel & $past(pin_irq_channel)) == $past(pin_irq_channel))
		else $error("pending request dropped without write");
	chk_prdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("prdata changed outside setup");
	chk_pad_hold: assert property (!$past(wr_acc) && !$past(rst)
		&& $stable(gpio_out) && $stable(gpio_oe) && $stable(periph_out) && $stable(periph_oe)
		|=> $stable(pad_out) && $stable(pad_oe))
		else $error("pad changed with steady sources");
	cov_err: cover property (pslverr);
	cov_irq: cover property ($rose(irq));
	cov_ch3: cover property (pin_irq_channel[3]);
	cov_drive: cover property (pad_oe != 32'h0);
endmodule

bind ppi_top ppi_top_monitor mon (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.gpio_out(gpio_out), .gpio_oe(gpio_oe), .periph_out(periph_out), .periph_oe(periph_oe),
	.pad_out(pad_out), .pad_oe(pad_oe), .rx_data(rx_data),
	.pin_irq_channel(pin_irq_channel), .irq(irq));

/* File: verification/ppi_top_bench.sv */
// Self-checking bench for ppi_top over APB, with pin drivers outside.
// Assumes zero-wait APB answers are possible but never relied on.
`timescale 1ns/1ps
module ppi_top_bench;
	import ppi_pkg::*;
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	logic         psel = 1'b0;
	logic         penable = 1'b0;
	logic         pwrite = 1'b0;
	logic [11:0]  paddr = 12'h000;
	logic [31:0]  pwdata = 32'h0000_0000;
	logic [31:0]  prdata, pad_in, pad_out, pad_oe, rx_data, rq;
	logic         pready, pslverr, irq, re;
	logic [31:0]  gpio_out = 32'h0000_0000;
	logic [31:0]  gpio_oe = 32'h0000_0000;
	logic [127:0] periph_out = 128'h0;
	logic [127:0] periph_oe = 128'h0;
	logic [31:0]  ext_lvl = 32'h0000_0000;
	logic [31:0]  fight = 32'h0000_0000;
	logic [3:0]   pin_irq_channel;
	int           err_total = 0;
	int           compares = 0;
	always #2.5 clk = ~clk;
	ppi_top uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .periph_out(periph_out),
		.periph_oe(periph_oe), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.rx_data(rx_data), .pin_irq_channel(pin_irq_channel), .irq(irq));
	ppi_pins pins (.pad_out(pad_out), .pad_oe(pad_oe), .ext_lvl(ext_lvl), .fight(fight),
		.pad_in(pad_in));
	////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		if (err_total == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask
	// One APB transfer; an idle cycle always separates two of them
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
		begin
			n++;
			if (n > 50)
			begin
				err_total++;
				summarize();
			end
			@(posedge clk);
		end
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a);
		xfer(1'b0, a, 32'h0000_0000);
	endtask
	function automatic logic [11:0] ca(input int c, input logic [5:0] o);
		return 12'(c << PPI_CH_SH) | {6'h00, o};
	endfunction
	task automatic wait_ch(input logic [3:0] exp);
		int n;
		n = 0;
		while (pin_irq_channel !== exp && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		check("pin_irq_channel", {28'h0, exp}, {28'h0, pin_irq_channel});
		check("irq", {31'h0, exp != 4'h0}, {31'h0, irq});
		if (n == 20)
			summarize();
	endtask
	task automatic clr_all();
		repeat (4) @(posedge clk);
		for (int c = 0; c < PPI_NCH; c++)
			wr(ca(c, PPI_OFS_LAT), 32'hFFFF_FFFF);
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic s_reset();
		for (int c = 0; c < PPI_NCH; c++)
		begin
			rd(ca(c, PPI_OFS_ASSIGN));
			check("assign", {24'h0, PPI_RST_ASSIGN}, rq);
			rd(ca(c, PPI_OFS_MSK_SET));
			check("mask", 32'h0000_0000, rq);
		end
		rd(PPI_MUX_BASE);
		check("mux", 32'h0000_0000, rq);
		rd(12'h200);
		check("unmapped err", 32'h0000_0001, {31'h0, re});
		check("unmapped data", 32'h0000_0000, rq);
		wr(ca(0, PPI_OFS_PINSTATE), 32'hFFFF_FFFF);
		check("pinstate err", 32'h0000_0000, {31'h0, re});
		rd(ca(0, PPI_OFS_PINSTATE));
		check("pinstate", 32'h0000_0000, rq);
	endtask
	task automatic s_setclr();
		wr(ca(0, PPI_OFS_MSK_SET), 32'h0000_00F0);
		wr(ca(0, PPI_OFS_MSK_SET), 32'h0000_0003);
		rd(ca(0, PPI_OFS_MSK_SET));
		check("mask set", 32'h0000_00F3, rq);
		wr(ca(0, PPI_OFS_MSK_CLR), 32'h0000_0010);
		rd(ca(0, PPI_OFS_MSK_CLR));
		check("mask clr", 32'h0000_00E3, rq);
		wr(ca(0, PPI_OFS_MSK_CLR), 32'hFFFF_FFFF);
		wr(ca(2, PPI_OFS_LAT_SET), 32'h8000_0000);
		rd(ca(2, PPI_OFS_LAT));
		check("latch set", 32'h8000_0000, rq);
		wait_ch(4'h0);
		wr(ca(2, PPI_OFS_MSK_SET), 32'h8000_0000);
		wait_ch(4'h4);
		wr(ca(2, PPI_OFS_LAT), 32'h8000_0000);
		wait_ch(4'h0);
		wr(ca(2, PPI_OFS_MSK_CLR), 32'h8000_0000);
	endtask
	task automatic s_edge();
		wr(ca(0, PPI_OFS_EDGE_SET), 32'h0000_0001);
		wr(ca(0, PPI_OFS_MSK_SET), 32'h0000_0001);
		ext_lvl <= 32'h0000_0001;
		wait_ch(4'h1);
		wr(ca(0, PPI_OFS_LAT), 32'h0000_0001);
		wait_ch(4'h0);
		repeat (6) @(posedge clk);
		rd(ca(0, PPI_OFS_LAT));
		check("edge latch", 32'h0000_0000, rq);
		rd(ca(1, PPI_OFS_LAT));
		check("unmasked latch", 32'h0000_0001, rq);
		rd(ca(1, PPI_OFS_REQ));
		check("masked req", 32'h0000_0000, rq);
		ext_lvl <= 32'h0000_0000;
		repeat (4) @(posedge clk);
		ext_lvl <= 32'h0000_0001;
		wait_ch(4'h1);
		rd(ca(0, PPI_OFS_REQ));
		check("req", 32'h0000_0001, rq);
		ext_lvl <= 32'h0000_0000;
		wr(ca(0, PPI_OFS_EDGE_CLR), 32'h0000_0001);
		wr(ca(0, PPI_OFS_MSK_CLR), 32'h0000_0001);
		clr_all();
	endtask
	task automatic s_level();
		wr(ca(0, PPI_OFS_MSK_SET), 32'h0000_0004);
		wr(ca(0, PPI_OFS_INV_SET), 32'h0000_0004);
		wait_ch(4'h1);
		ext_lvl <= 32'h0000_0004;
		repeat (6) @(posedge clk);
		wait_ch(4'h1);
		wr(ca(0, PPI_OFS_LAT), 32'h0000_0004);
		repeat (6) @(posedge clk);
		wait_ch(4'h0);
		wr(ca(0, PPI_OFS_INV_CLR), 32'h0000_0004);
		wait_ch(4'h1);
		ext_lvl <= 32'h0000_0000;
		wr(ca(0, PPI_OFS_MSK_CLR), 32'h0000_0004);
		clr_all();
	endtask
	task automatic s_assign();
		wr(ca(3, PPI_OFS_ASSIGN), 32'h0000_00E5);
		ext_lvl <= 32'h0000_0200;
		repeat (6) @(posedge clk);
		rd(ca(3, PPI_OFS_LAT));
		check("half port latch", 32'h0000_0202, rq);
		rd(ca(3, PPI_OFS_PINSTATE));
		check("half port state", 32'h0000_0202, rq);
		wr(ca(3, PPI_OFS_MSK_SET), 32'h0000_0202);
		wait_ch(4'h8);
		wr(ca(3, PPI_OFS_MSK_CLR), 32'hFFFF_FFFF);
		ext_lvl <= 32'h0000_0000;
		wr(ca(3, PPI_OFS_ASSIGN), 32'h0000_00E4);
		clr_all();
	endtask
	task automatic s_mux();
		gpio_out <= 32'h0000_0020;
		gpio_oe <= 32'h0000_0020;
		repeat (6) @(posedge clk);
		check("pad_out gpio", 32'h0000_0020, pad_out);
		rd(ca(1, PPI_OFS_LAT));
		check("output pin latch", 32'h0000_0020, rq);
		for (int s = 1; s < 6; s++)
		begin
			gpio_out <= 32'h0000_0000;
			gpio_oe <= 32'h0000_0000;
			periph_out <= {96'h0, 32'h0000_0020} << (32 * (s - 1));
			periph_oe <= {96'h0, 32'h0000_0020} << (32 * (s - 1));
			wr(PPI_MUX_BASE, 32'(s) << 20);
			repeat (2) @(posedge clk);
			check("pad_out sel", (s < 5) ? 32'h0000_0020 : 32'h0000_0000, pad_out);
			check("pad_oe sel", (s < 5) ? 32'h0000_0020 : 32'h0000_0000, pad_oe);
		end
		periph_out <= {96'h0, 32'h0000_0020};
		periph_oe <= {96'h0, 32'h0000_0020};
		fight <= 32'h0000_0020;
		wr(PPI_MUX_BASE, 32'h0010_0000);
		wr(PPI_OFS_IEN, 32'h0000_0020);
		repeat (3) @(posedge clk);
		check("rx loopback", 32'h0000_0020, rx_data);
		wr(PPI_OFS_IEN, 32'h0000_0000);
		repeat (3) @(posedge clk);
		check("rx disabled", 32'h0000_0000, rx_data);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		s_reset();
		s_setclr();
		s_edge();
		s_level();
		s_assign();
		s_mux();
		summarize();
	end
endmodule
